// ---- pif_periph_flags.sv ----
// Peripheral interrupt flag registers, their enables and the combined request.
`timescale 1ns/1ps
module pif_periph_flags
   import pif_pkg::*;
#(
   parameter int NUM_CAPCOMP = 5,
   parameter int NUM_GATES = 3
) (
   input wire logic core_clk,
   input wire logic rst,
   // Register port.
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [DATA_W-1:0] regRdData,
   // Event pulses from on-chip peripherals, same clock.
   input wire logic convDone,
   input wire logic serial1RxLoaded,
   input wire logic serial1RxBufRead,
   input wire logic serial1TxBufFreed,
   input wire logic serial1TxBufWrite,
   input wire logic syncPort1Done,
   input wire logic syncPort1Collision,
   input wire logic syncPort2Done,
   input wire logic syncPort2Collision,
   input wire logic syncPort2MasterTx,
   input wire logic serial2RxLoaded,
   input wire logic serial2RxBufRead,
   input wire logic serial2TxBufFreed,
   input wire logic serial2TxBufWrite,
   input wire logic [NUM_CAPCOMP-1:0] capcompEvent,
   input wire logic [NUM_CAPCOMP-1:0] capcompPwmMode,
   input wire logic timer1Overflow,
   input wire logic timer2Match,
   input wire logic timer3Overflow,
   input wire logic timer4Match,
   input wire logic timer5Overflow,
   input wire logic timer6Match,
   input wire logic [NUM_GATES-1:0] timerGateEvent,
   input wire logic oscFailSwitched,
   input wire logic nvWriteDone,
   input wire logic chargeTimeEvent,
   // Analog levels from outside the clock domain.
   input wire logic comparator1Out,
   input wire logic comparator2Out,
   input wire logic voltageAboveTrip,
   // Request and control outputs.
   output logic periphIrqReq,
   output logic periphIrqGated,
   output logic priorityModeEnable,
   output logic peripheralGlobalEnable
);
   localparam int NUM_FLAG_REGS = 5;
   if (NUM_CAPCOMP != 5 || NUM_GATES != 3) begin : gBadParams
      $error("pif_periph_flags: unsupported unit counts");
   end

   // True when a register access targets the given offset.
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] ofs);
      hit = (addr == ofs);
   endfunction

   // Capture or compare event that counts only outside PWM mode.
   function automatic logic ccEvent(input logic ev, input logic pwm);
      ccEvent = ev & ~pwm;
   endfunction

   // Edges of the synchronised analog levels.
   logic comp1Rise, comp1Fall;
   logic comp2Rise, comp2Fall;
   logic lvRise, lvFall;

   pif_sync_edge #(
      .RESET_LEVEL(1'b0)
   ) u_comp1 (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn(comparator1Out),
      .level(),
      .rise(comp1Rise),
      .fall(comp1Fall)
   );
   pif_sync_edge #(
      .RESET_LEVEL(1'b0)
   ) u_comp2 (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn(comparator2Out),
      .level(),
      .rise(comp2Rise),
      .fall(comp2Fall)
   );

   // Resetting to high keeps a supply already above trip from raising a
   // spurious rising event right after reset.
   pif_sync_edge #(
      .RESET_LEVEL(1'b1)
   ) u_lowvolt (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn(voltageAboveTrip),
      .level(),
      .rise(lvRise),
      .fall(lvFall)
   );

   // Control registers: priority mode, global enable, direction.
   logic [DATA_W-1:0] control_q, control_d;
   logic [DATA_W-1:0] lvControl_q, lvControl_d;
   logic [DATA_W-1:0] enable_q [NUM_FLAG_REGS];
   logic [DATA_W-1:0] enable_d [NUM_FLAG_REGS];
   logic [DATA_W-1:0] enableMask [NUM_FLAG_REGS];
   logic [ADDR_W-1:0] enableOfs [NUM_FLAG_REGS];
   logic voltageDirectionSelect;
   assign enableMask[0] = IMPL_FLAGS1;
   assign enableMask[1] = IMPL_FULL;
   assign enableMask[2] = IMPL_FULL;
   assign enableMask[3] = IMPL_LOW3;
   assign enableMask[4] = IMPL_LOW3;
   assign enableOfs[0] = OFS_ENABLE1;
   assign enableOfs[1] = OFS_ENABLE2;
   assign enableOfs[2] = OFS_ENABLE3;
   assign enableOfs[3] = OFS_ENABLE4;
   assign enableOfs[4] = OFS_ENABLE5;
   always_comb begin
      control_d = control_q;
      lvControl_d = lvControl_q;
      for (int i = 0; i < NUM_FLAG_REGS; i++) begin
         enable_d[i] = enable_q[i];
      end
      if (regWrStb) begin
         if (hit(regAddr, OFS_CONTROL)) begin
            control_d = DATA_ZERO;
            control_d[CTL_PRIORITY_MODE] = regWrData[CTL_PRIORITY_MODE];
            control_d[CTL_GLOBAL_ENABLE] = regWrData[CTL_GLOBAL_ENABLE];
         end
         if (hit(regAddr, OFS_LV_CONTROL)) begin
            lvControl_d = DATA_ZERO;
            lvControl_d[LVC_DIRECTION] = regWrData[LVC_DIRECTION];
         end
         for (int i = 0; i < NUM_FLAG_REGS; i++) begin
            if (hit(regAddr, enableOfs[i])) begin
               enable_d[i] = regWrData & enableMask[i];
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         control_q <= DATA_ZERO;
         lvControl_q <= DATA_ZERO;
         for (int i = 0; i < NUM_FLAG_REGS; i++) begin
            enable_q[i] <= DATA_ZERO;
         end
      end else begin
         control_q <= control_d;
         lvControl_q <= lvControl_d;
         for (int i = 0; i < NUM_FLAG_REGS; i++) begin
            enable_q[i] <= enable_d[i];
         end
      end
   end

   assign priorityModeEnable = control_q[CTL_PRIORITY_MODE];
   assign peripheralGlobalEnable = control_q[CTL_GLOBAL_ENABLE];
   assign voltageDirectionSelect = lvControl_q[LVC_DIRECTION];

   // Set and clear events. No enable bit takes part here, so software
   // can poll any flag with its interrupt disabled.
   logic [DATA_W-1:0] set1, set2, set3, set4, set5;
   logic [DATA_W-1:0] clr1, clr3;
   logic lvEvent;

   // Direction high flags a rise through the trip point, low a fall.
   assign lvEvent = voltageDirectionSelect ? lvRise : lvFall;

   always_comb begin
      set1 = DATA_ZERO;
      clr1 = DATA_ZERO;
      set1[F1_CONV_DONE] = convDone;
      set1[F1_SER1_RX] = serial1RxLoaded;
      clr1[F1_SER1_RX] = serial1RxBufRead;
      set1[F1_SER1_TX] = serial1TxBufFreed;
      clr1[F1_SER1_TX] = serial1TxBufWrite;
      set1[F1_SYNC1_DONE] = syncPort1Done;
      set1[F1_CAPCOMP1] = ccEvent(capcompEvent[CC1], capcompPwmMode[CC1]);
      set1[F1_TIMER2_MATCH] = timer2Match;
      set1[F1_TIMER1_OVF] = timer1Overflow;
   end

   always_comb begin
      set2 = DATA_ZERO;
      set2[F2_OSC_FAIL] = oscFailSwitched;
      set2[F2_COMP1] = comp1Rise | comp1Fall;
      set2[F2_COMP2] = comp2Rise | comp2Fall;
      set2[F2_NV_WRITE] = nvWriteDone;
      set2[F2_SYNC1_COLL] = syncPort1Collision;
      set2[F2_LOW_VOLT] = lvEvent;
      set2[F2_TIMER3_OVF] = timer3Overflow;
      set2[F2_CAPCOMP2] = ccEvent(capcompEvent[CC2], capcompPwmMode[CC2]);
   end

   always_comb begin
      set3 = DATA_ZERO;
      clr3 = DATA_ZERO;
      set3[F3_SYNC2_DONE] = syncPort2Done;
      set3[F3_SYNC2_COLL] = syncPort2Collision & syncPort2MasterTx;
      set3[F3_SER2_RX] = serial2RxLoaded;
      clr3[F3_SER2_RX] = serial2RxBufRead;
      set3[F3_SER2_TX] = serial2TxBufFreed;
      clr3[F3_SER2_TX] = serial2TxBufWrite;
      set3[F3_CHARGE_TIME] = chargeTimeEvent;
      set3[F3_TIMER5_GATE] = timerGateEvent[GATE_T5];
      set3[F3_TIMER3_GATE] = timerGateEvent[GATE_T3];
      set3[F3_TIMER1_GATE] = timerGateEvent[GATE_T1];
   end

   always_comb begin
      set4 = DATA_ZERO;
      set5 = DATA_ZERO;
      set4[F4_CAPCOMP5] = ccEvent(capcompEvent[CC5], capcompPwmMode[CC5]);
      set4[F4_CAPCOMP4] = ccEvent(capcompEvent[CC4], capcompPwmMode[CC4]);
      set4[F4_CAPCOMP3] = ccEvent(capcompEvent[CC3], capcompPwmMode[CC3]);
      set5[F5_TIMER6_MATCH] = timer6Match;
      set5[F5_TIMER5_OVF] = timer5Overflow;
      set5[F5_TIMER4_MATCH] = timer4Match;
   end

   // Flag registers. A set in the cycle of a clearing write wins.
   logic [DATA_W-1:0] flags [NUM_FLAG_REGS];

   pif_flag_reg #(
      .WIDTH(DATA_W),
      .IMPL_MASK(IMPL_FLAGS1),
      .WR_MASK(WR_FLAGS1),
      .RESET_VAL(FLAGS_RESET)
   ) u_flags1 (
      .core_clk(core_clk),
      .rst(rst),
      .wrEn(regWrStb & hit(regAddr, OFS_FLAGS1)),
      .wrData(regWrData),
      .setEv(set1),
      .clrEv(clr1),
      .flags(flags[0])
   );
   pif_flag_reg #(
      .WIDTH(DATA_W),
      .IMPL_MASK(IMPL_FULL),
      .WR_MASK(IMPL_FULL),
      .RESET_VAL(FLAGS_RESET)
   ) u_flags2 (
      .core_clk(core_clk),
      .rst(rst),
      .wrEn(regWrStb & hit(regAddr, OFS_FLAGS2)),
      .wrData(regWrData),
      .setEv(set2),
      .clrEv(DATA_ZERO),
      .flags(flags[1])
   );

   // The serial buffer bits follow the buffers, so software writes skip them.
   pif_flag_reg #(
      .WIDTH(DATA_W),
      .IMPL_MASK(IMPL_FULL),
      .WR_MASK(WR_FLAGS3),
      .RESET_VAL(FLAGS_RESET)
   ) u_flags3 (
      .core_clk(core_clk),
      .rst(rst),
      .wrEn(regWrStb & hit(regAddr, OFS_FLAGS3)),
      .wrData(regWrData),
      .setEv(set3),
      .clrEv(clr3),
      .flags(flags[2])
   );
   pif_flag_reg #(
      .WIDTH(DATA_W),
      .IMPL_MASK(IMPL_LOW3),
      .WR_MASK(IMPL_LOW3),
      .RESET_VAL(FLAGS_RESET)
   ) u_flags4 (
      .core_clk(core_clk),
      .rst(rst),
      .wrEn(regWrStb & hit(regAddr, OFS_FLAGS4)),
      .wrData(regWrData),
      .setEv(set4),
      .clrEv(DATA_ZERO),
      .flags(flags[3])
   );
   pif_flag_reg #(
      .WIDTH(DATA_W),
      .IMPL_MASK(IMPL_LOW3),
      .WR_MASK(IMPL_LOW3),
      .RESET_VAL(FLAGS_RESET)
   ) u_flags5 (
      .core_clk(core_clk),
      .rst(rst),
      .wrEn(regWrStb & hit(regAddr, OFS_FLAGS5)),
      .wrData(regWrData),
      .setEv(set5),
      .clrEv(DATA_ZERO),
      .flags(flags[4])
   );

   // Request. The gated form needs the global enable in both priority
   // modes, since one bit serves as peripheral and low-priority enable.
   logic irqReq_q, irqReq_d;
   logic irqGated_q, irqGated_d;

   always_comb begin
      irqReq_d = 1'b0;
      for (int i = 0; i < NUM_FLAG_REGS; i++) begin
         irqReq_d = irqReq_d | (|(flags[i] & enable_q[i]));
      end
      irqGated_d = irqReq_d & peripheralGlobalEnable;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irqReq_q <= 1'b0;
         irqGated_q <= 1'b0;
      end else begin
         irqReq_q <= irqReq_d;
         irqGated_q <= irqGated_d;
      end
   end

   assign periphIrqReq = irqReq_q;
   assign periphIrqGated = irqGated_q;

   // Read port: data stand only in the cycle after the strobe.
   logic [DATA_W-1:0] rdData_q, rdData_d;

   always_comb begin
      rdData_d = DATA_ZERO;
      if (regRdStb) begin
         case (regAddr)
            OFS_FLAGS1: rdData_d = flags[0];
            OFS_FLAGS2: rdData_d = flags[1];
            OFS_FLAGS3: rdData_d = flags[2];
            OFS_FLAGS4: rdData_d = flags[3];
            OFS_FLAGS5: rdData_d = flags[4];
            OFS_ENABLE1: rdData_d = enable_q[0];
            OFS_ENABLE2: rdData_d = enable_q[1];
            OFS_ENABLE3: rdData_d = enable_q[2];
            OFS_ENABLE4: rdData_d = enable_q[3];
            OFS_ENABLE5: rdData_d = enable_q[4];
            OFS_CONTROL: rdData_d = control_q;
            OFS_LV_CONTROL: rdData_d = lvControl_q;
            default: rdData_d = DATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdData_q <= DATA_ZERO;
      end else begin
         rdData_q <= rdData_d;
      end
   end

   assign regRdData = rdData_q;
endmodule // pif_periph_flags

// ---- pif_pkg.sv ----
// Register map, field layout and reset values of the peripheral flag block.
// Notes on behaviour
// - conversion done sets flag, software clears
// - serial1 receive flag read-only, cleared by buffer read
// - serial1 transmit flag read-only, cleared by buffer write
// - sync port1 completion sets flag, software clears
// - capture events set capcomp1/2 flags
// - compare match sets capcomp1/2, except in PWM mode
// - timer2 period match sets flag, software clears
// - timer1 rollover sets flag, software clears
// - oscillator failover sets flag, software clears
// - comparator output change sets its flag
// - nonvolatile write completion sets flag
// - sync port1 bus collision sets flag
// - low-voltage flag; direction bit selects crossing
// - timer3 rollover sets flag, software clears
// - port2 collision only as I2C master transmitting
// - serial2 receive/transmit flags follow buffer state
// - charge time unit event sets flag
// - timer1/3/5 gate events set separate flags
// - capcomp3-5 flags set except in PWM
// - timer6/4 match, timer5 overflow set flags
// - unimplemented bits always read zero
// - flags set regardless of any enable
package pif_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets on the register port.
   localparam logic [ADDR_W-1:0] OFS_FLAGS1 = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_FLAGS2 = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_FLAGS3 = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_FLAGS4 = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_FLAGS5 = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_ENABLE1 = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_ENABLE2 = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_ENABLE3 = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_ENABLE4 = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_ENABLE5 = 4'h9;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'hA;
   localparam logic [ADDR_W-1:0] OFS_LV_CONTROL = 4'hB;

   // Implemented bits, software-writable bits and reset values.
   localparam logic [DATA_W-1:0] IMPL_FLAGS1 = 8'h7F;
   localparam logic [DATA_W-1:0] IMPL_FULL = 8'hFF;
   localparam logic [DATA_W-1:0] IMPL_LOW3 = 8'h07;
   localparam logic [DATA_W-1:0] WR_FLAGS1 = 8'h4F;
   localparam logic [DATA_W-1:0] WR_FLAGS3 = 8'hCF;
   localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

   // Flag register one.
   localparam int F1_CONV_DONE = 6;
   localparam int F1_SER1_RX = 5;
   localparam int F1_SER1_TX = 4;
   localparam int F1_SYNC1_DONE = 3;
   localparam int F1_CAPCOMP1 = 2;
   localparam int F1_TIMER2_MATCH = 1;
   localparam int F1_TIMER1_OVF = 0;
   // Flag register two.
   localparam int F2_OSC_FAIL = 7;
   localparam int F2_COMP1 = 6;
   localparam int F2_COMP2 = 5;
   localparam int F2_NV_WRITE = 4;
   localparam int F2_SYNC1_COLL = 3;
   localparam int F2_LOW_VOLT = 2;
   localparam int F2_TIMER3_OVF = 1;
   localparam int F2_CAPCOMP2 = 0;
   // Flag register three.
   localparam int F3_SYNC2_DONE = 7;
   localparam int F3_SYNC2_COLL = 6;
   localparam int F3_SER2_RX = 5;
   localparam int F3_SER2_TX = 4;
   localparam int F3_CHARGE_TIME = 3;
   localparam int F3_TIMER5_GATE = 2;
   localparam int F3_TIMER3_GATE = 1;
   localparam int F3_TIMER1_GATE = 0;
   // Flag register four.
   localparam int F4_CAPCOMP5 = 2;
   localparam int F4_CAPCOMP4 = 1;
   localparam int F4_CAPCOMP3 = 0;
   // Flag register five.
   localparam int F5_TIMER6_MATCH = 2;
   localparam int F5_TIMER5_OVF = 1;
   localparam int F5_TIMER4_MATCH = 0;
   // Control registers.
   localparam int CTL_PRIORITY_MODE = 0;
   localparam int CTL_GLOBAL_ENABLE = 1;
   localparam int LVC_DIRECTION = 0;

   // Indices into the capture/compare and timer gate vectors.
   localparam int CC1 = 0;
   localparam int CC2 = 1;
   localparam int CC3 = 2;
   localparam int CC4 = 3;
   localparam int CC5 = 4;
   localparam int GATE_T1 = 0;
   localparam int GATE_T3 = 1;
   localparam int GATE_T5 = 2;

endpackage

// ---- pif_sync_edge.sv ----
// Two-stage synchroniser with rise and fall detection.
`timescale 1ns/1ps
module pif_sync_edge
   import pif_pkg::*;
#(
   parameter logic RESET_LEVEL = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic asyncIn,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic last_q, last_d;

   // Only sync_q reads meta_q; the edge logic looks at sync_q and last_q.
   always_comb begin
      meta_d = asyncIn;
      sync_d = meta_q;
      last_d = sync_q;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q <= RESET_LEVEL;
         sync_q <= RESET_LEVEL;
         last_q <= RESET_LEVEL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   assign level = sync_q;
   assign rise = sync_q & ~last_q;
   assign fall = ~sync_q & last_q;
endmodule // pif_sync_edge

// ---- pif_flag_reg.sv ----
// Sticky flag register with software write, hardware set and hardware clear.
`timescale 1ns/1ps
module pif_flag_reg
   import pif_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter logic [WIDTH-1:0] IMPL_MASK = '1,
   parameter logic [WIDTH-1:0] WR_MASK = '1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wrEn,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic [WIDTH-1:0] setEv,
   input wire logic [WIDTH-1:0] clrEv,
   output logic [WIDTH-1:0] flags
);
   logic [WIDTH-1:0] flags_q, flags_d;

   if (WIDTH < 1 || WIDTH > DATA_W) begin : gBadWidth
      $error("pif_flag_reg: WIDTH out of range");
   end

   always_comb begin
      flags_d = flags_q;
      if (wrEn) begin
         flags_d = (flags_q & ~WR_MASK) | (wrData & WR_MASK);
      end
      flags_d = flags_d & ~clrEv;
      flags_d = (flags_d | setEv) & IMPL_MASK;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_q <= RESET_VAL & IMPL_MASK;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;
endmodule // pif_flag_reg

// ---- pif_periph_model.sv ----
// Stand-in for the peripherals that raise events and drive analog levels.
`timescale 1ns/1ps
module pif_periph_model (
   input wire logic [29:0] fire,
   input wire logic masterIn,
   input wire logic [4:0] pwmIn,
   input wire logic [1:0] cmpIn,
   input wire logic voltIn,
   output logic convDone,
   output logic serial1RxLoaded,
   output logic serial1RxBufRead,
   output logic serial1TxBufFreed,
   output logic serial1TxBufWrite,
   output logic syncPort1Done,
   output logic syncPort1Collision,
   output logic syncPort2Done,
   output logic syncPort2Collision,
   output logic syncPort2MasterTx,
   output logic serial2RxLoaded,
   output logic serial2RxBufRead,
   output logic serial2TxBufFreed,
   output logic serial2TxBufWrite,
   output logic [4:0] capcompEvent,
   output logic [4:0] capcompPwmMode,
   output logic timer1Overflow,
   output logic timer2Match,
   output logic timer3Overflow,
   output logic timer4Match,
   output logic timer5Overflow,
   output logic timer6Match,
   output logic [2:0] timerGateEvent,
   output logic oscFailSwitched,
   output logic nvWriteDone,
   output logic chargeTimeEvent,
   output logic comparator1Out,
   output logic comparator2Out,
   output logic voltageAboveTrip
);
   // Each event is a single-cycle pulse, so several may land on one edge.
   assign {serial2TxBufWrite, serial2RxBufRead, serial1TxBufWrite, serial1RxBufRead,
      timer4Match, timer5Overflow, timer6Match, capcompEvent[2], capcompEvent[3],
      capcompEvent[4], timerGateEvent[0], timerGateEvent[1], timerGateEvent[2],
      chargeTimeEvent, serial2TxBufFreed, serial2RxLoaded, syncPort2Collision,
      syncPort2Done, capcompEvent[1], timer3Overflow, syncPort1Collision, nvWriteDone,
      oscFailSwitched, timer1Overflow, timer2Match, capcompEvent[0], syncPort1Done,
      serial1TxBufFreed, serial1RxLoaded, convDone} = fire;
   assign syncPort2MasterTx = masterIn;
   assign capcompPwmMode = pwmIn;
   assign {comparator2Out, comparator1Out} = cmpIn;
   assign voltageAboveTrip = voltIn;
endmodule // pif_periph_model

// ---- pif_periph_flags_properties.sv ----
// Port-level assertions for the peripheral flag block.
`timescale 1ns/1ps
module pif_periph_flags_properties
   import pif_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [DATA_W-1:0] regRdData,
   input wire logic convDone,
   input wire logic serial1RxLoaded,
   input wire logic serial1RxBufRead,
   input wire logic periphIrqReq,
   input wire logic periphIrqGated,
   input wire logic priorityModeEnable,
   input wire logic peripheralGlobalEnable
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   sequence seqRead1;
      regRdStb && regAddr == OFS_FLAGS1;
   endsequence
   sequence seqConvSeen;
      convDone ##1 !(regWrStb && regAddr == OFS_FLAGS1) ##1 seqRead1;
   endsequence
   sequence seqRxDrained;
      serial1RxBufRead && !serial1RxLoaded ##1 !serial1RxLoaded ##1 seqRead1;
   endsequence
   chk_conv_flag_sticky: assert property (seqConvSeen |=> regRdData[F1_CONV_DONE])
      else $error("conversion flag lost");
   chk_rx_flag_cleared: assert property (seqRxDrained |=> !regRdData[F1_SER1_RX])
      else $error("receive flag not cleared");
   chk_idle_read_zero: assert property (!regRdStb |=> regRdData == DATA_ZERO)
      else $error("idle read data not zero");
   chk_unmapped_zero: assert property (regRdStb && regAddr > OFS_LV_CONTROL |=> regRdData == DATA_ZERO)
      else $error("unmapped offset read not zero");
   chk_upper_bits_zero: assert property (regRdStb && (regAddr == OFS_FLAGS4 || regAddr == OFS_FLAGS5)
      |=> regRdData[7:3] == 5'h00)
      else $error("unimplemented bits read as one");
   chk_flags1_top_zero: assert property (seqRead1 |=> !regRdData[7])
      else $error("flags one top bit set");
   chk_gated_needs_enable: assert property (periphIrqGated |-> periphIrqReq && $past(peripheralGlobalEnable))
      else $error("gated request without global enable");
   chk_ctrl_write: assert property (regWrStb && regAddr == OFS_CONTROL |=>
      peripheralGlobalEnable == $past(regWrData[CTL_GLOBAL_ENABLE]) &&
      priorityModeEnable == $past(regWrData[CTL_PRIORITY_MODE]))
      else $error("control write not taken");
   chk_ctrl_hold: assert property (!(regWrStb && regAddr == OFS_CONTROL) |=>
      $stable({peripheralGlobalEnable, priorityModeEnable}))
      else $error("control bits changed unwritten");
endmodule // pif_periph_flags_properties

bind pif_periph_flags pif_periph_flags_properties pif_periph_flags_properties_inst (
   .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
   .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .convDone(convDone),
   .serial1RxLoaded(serial1RxLoaded), .serial1RxBufRead(serial1RxBufRead),
   .periphIrqReq(periphIrqReq), .periphIrqGated(periphIrqGated),
   .priorityModeEnable(priorityModeEnable), .peripheralGlobalEnable(peripheralGlobalEnable));

// ---- tb_top.sv ----
// Self-checking bench for the peripheral flag block.
`timescale 1ns/1ps
module tb_top;
   import pif_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWrData = '0;
   logic regWrStb = 1'b0;
   logic regRdStb = 1'b0;
   logic [DATA_W-1:0] regRdData;
   logic periphIrqReq, periphIrqGated, priorityModeEnable, peripheralGlobalEnable;
   logic [29:0] fire = '0;
   logic masterIn = 1'b1;
   logic [4:0] pwmIn = '0;
   logic [1:0] cmpIn = '0;
   logic voltIn = 1'b1;
   logic convDone, serial1RxLoaded, serial1RxBufRead, serial1TxBufFreed, serial1TxBufWrite;
   logic syncPort1Done, syncPort1Collision, syncPort2Done, syncPort2Collision, syncPort2MasterTx;
   logic serial2RxLoaded, serial2RxBufRead, serial2TxBufFreed, serial2TxBufWrite;
   logic timer1Overflow, timer2Match, timer3Overflow, timer4Match, timer5Overflow, timer6Match;
   logic oscFailSwitched, nvWriteDone, chargeTimeEvent;
   logic comparator1Out, comparator2Out, voltageAboveTrip;
   logic [4:0] capcompEvent, capcompPwmMode;
   logic [2:0] timerGateEvent;
   int miscompares = 0;
   int samplesChecked = 0;
   int cyc = 0;
   logic [7:0] mdl [5] = '{default: 8'h00};
   // Writable bits of flags, then implemented bits of enables and controls.
   const logic [7:0] msk [12] = '{8'h4F, 8'hFF, 8'hCF, 8'h07, 8'h07, 8'h7F, 8'hFF, 8'hFF,
      8'h07, 8'h07, 8'h03, 8'h01};
   // Flag position (register times eight plus bit) hit by each fire line.
   const int pos [30] = '{6, 5, 4, 3, 2, 1, 0, 15, 12, 11, 9, 8, 23, 22, 21, 20, 19, 18, 17,
      16, 26, 25, 24, 34, 33, 32, 5, 4, 21, 20};

   pif_periph_model pif_periph_model_inst (.*);
   pif_periph_flags pif_periph_flags_inst (.*);

   always #25 core_clk = ~core_clk;

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Ceiling far above the four hundred or so cycles the tests take.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         complete_run();
      end
   end

   task chk(input logic [7:0] g, input logic [7:0] e);
      samplesChecked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t got %h expected %h", $time, g, e);
      end
   endtask

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge core_clk);
      regWrStb <= 1'b0;
      if (a < 4'h5) begin
         mdl[a] = (mdl[a] & ~msk[a]) | (d & msk[a]);
      end
   endtask

   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      #1;
      chk(regRdData, e);
   endtask

   task fireEv(input int i, input bit s);
      @(posedge core_clk);
      fire <= 30'(1) << i;
      @(posedge core_clk);
      fire <= '0;
      if (i > 25) begin
         mdl[pos[i] / 8][pos[i] % 8] = 1'b0;
      end else if (s) begin
         mdl[pos[i] / 8][pos[i] % 8] = 1'b1;
      end
   endtask

   task automatic clearAll();
      for (int k = 0; k < 11; k++) wr(4'(k), 8'h00);
      for (int k = 26; k < 30; k++) fireEv(k, 1'b1);
      for (int k = 0; k < 5; k++) rd(4'(k), mdl[k]);
   endtask

   task irqChk(input logic [7:0] e);
      repeat (2) @(posedge core_clk);
      #1;
      chk({6'h00, periphIrqGated, periphIrqReq}, e);
   endtask

   initial begin
      int a;
      logic [7:0] d;
      void'($urandom(94));
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      for (a = 0; a < 16; a++) rd(4'(a), 8'h00);
      $display("test reset done");
      for (a = 0; a < 26; a++) begin
         fireEv(a, 1'b1);
         rd(4'(pos[a] / 8), mdl[pos[a] / 8]);
      end
      $display("test events done");
      for (int p = 0; p < 2; p++) begin
         for (a = 0; a < 12; a++) begin
            d = (p == 0) ? 8'hFF : 8'($urandom);
            wr(4'(a), d);
            rd(4'(a), (a < 5) ? mdl[a] : (d & msk[a]));
         end
      end
      wr(4'hC, 8'hFF);
      rd(4'hC, 8'h00);
      $display("test registers done");
      clearAll();
      @(posedge core_clk);
      fire <= 30'h0400_0003;
      regAddr <= OFS_FLAGS1;
      regWrData <= 8'h00;
      regWrStb <= 1'b1;
      @(posedge core_clk);
      fire <= '0;
      regWrStb <= 1'b0;
      mdl[0] = 8'h60;
      rd(OFS_FLAGS1, mdl[0]);
      fireEv(26, 1'b1);
      rd(OFS_FLAGS1, mdl[0]);
      $display("test priority done");
      @(posedge core_clk);
      pwmIn <= 5'h1F;
      masterIn <= 1'b0;
      fireEv(4, 1'b0);
      fireEv(22, 1'b0);
      fireEv(13, 1'b0);
      rd(OFS_FLAGS1, mdl[0]);
      rd(OFS_FLAGS4, mdl[3]);
      rd(OFS_FLAGS3, mdl[2]);
      $display("test refusals done");
      wr(OFS_LV_CONTROL, 8'h00);
      wr(OFS_FLAGS2, 8'h00);
      @(posedge core_clk);
      cmpIn <= 2'b11;
      voltIn <= 1'b0;
      repeat (6) @(posedge core_clk);
      rd(OFS_FLAGS2, 8'h64);
      wr(OFS_FLAGS2, 8'h00);
      wr(OFS_LV_CONTROL, 8'h01);
      @(posedge core_clk);
      voltIn <= 1'b1;
      repeat (6) @(posedge core_clk);
      rd(OFS_FLAGS2, 8'h04);
      $display("test analog done");
      clearAll();
      fireEv(25, 1'b1);
      wr(OFS_ENABLE5, 8'h01);
      irqChk(8'h01);
      wr(OFS_CONTROL, 8'h02);
      irqChk(8'h03);
      wr(OFS_FLAGS5, 8'h00);
      irqChk(8'h00);
      $display("test request done");
      complete_run();
   end
endmodule // tb_top
